/* include/spims_pkg.sv */
// register map, field positions and pin carriers of the dual serial port
package spims_pkg;

   // ==========================================================================
   // register indexes (byte address is four times the index)
   // ==========================================================================
   localparam int MAX_PORTS = 2;
   localparam logic [7:0] SERIAL_DATA_0 = 8'hf0;
   localparam logic [7:0] SERIAL_CONTROL_0 = 8'hf1;
   localparam logic [7:0] SERIAL_FLAGS_0 = 8'hf2;
   localparam logic [7:0] SERIAL_DIVIDER_0 = 8'hf3;
   localparam logic [7:0] SERIAL_DATA_1 = 8'hf8;
   localparam logic [7:0] SERIAL_CONTROL_1 = 8'hf9;
   localparam logic [7:0] SERIAL_FLAGS_1 = 8'hfa;
   localparam logic [7:0] SERIAL_DIVIDER_1 = 8'hfb;
   localparam logic [7:0] REG_PAGE = 8'h07;   // page of both instances, not decoded
   localparam logic [7:0] DATA_IDX [MAX_PORTS] = '{SERIAL_DATA_0, SERIAL_DATA_1};
   localparam logic [7:0] CTRL_IDX [MAX_PORTS] = '{SERIAL_CONTROL_0, SERIAL_CONTROL_1};
   localparam logic [7:0] FLAGS_IDX [MAX_PORTS] = '{SERIAL_FLAGS_0, SERIAL_FLAGS_1};
   localparam logic [7:0] DIV_IDX [MAX_PORTS] = '{SERIAL_DIVIDER_0, SERIAL_DIVIDER_1};

   // ==========================================================================
   // control register fields
   // ==========================================================================
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_PIN_OE = 6;
   localparam int CTL_IRQ_SRC = 5;
   localparam int CTL_MASTER = 4;
   localparam int CTL_CPOL = 3;
   localparam int CTL_CPHA = 2;
   localparam int CTL_RATE_HI = 1;
   localparam int CTL_RATE_LO = 0;
   localparam logic [7:0] CTL_GUARD_MASK = 8'h50;   // output enable and master select
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ==========================================================================
   // status and divider fields
   // ==========================================================================
   localparam int ST_DONE = 7;
   localparam int ST_CLASH = 6;
   localparam int ST_FAULT = 4;
   localparam int DIV_HALF_BYPASS = 4;
   localparam int DIV_PRS_HI = 2;
   localparam logic [7:0] DIV_WMASK = 8'h17;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ==========================================================================
   // timing of a byte
   // ==========================================================================
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hf;   // sixteen serial clock edges per byte
   localparam int HALF_W = 9;
   // half-period shift per rate code: divide by 2, 4, 16, 32 gives 1, 2, 8, 16
   localparam logic [2:0] RATE_SHIFT [4] = '{3'h0, 3'h1, 3'h3, 3'h4};

   // ==========================================================================
   // pin carriers
   // ==========================================================================
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } spims_pin_in_t;

   typedef struct packed {
      logic sck;
      logic sck_oe_n;
      logic mosi;
      logic mosi_oe_n;
      logic miso;
      logic miso_oe_n;
   } spims_pin_out_t;

endpackage : spims_pkg

/* core/spims_port.sv */
// dual master/slave serial port with apb register access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - phase one: second clock edge samples first bit; falling at polarity 0.
// - phase zero: first clock edge samples first bit; rising at polarity 0.
// - phase zero slave with select low freezes data register; writes then are collisions.
// - phase one slave: select low across bytes alone is no collision.
// - a write during a transfer is dropped; the transfer continues unchanged.
// - collision sets the clash flag, which never raises an interrupt.
// - phase one slave drives first bit only after the first clock edge.
// - master flags a collision on a data write while its clock shifts.
// - master seeing select low sets fault flag, interrupts if enabled.
// - fault clears output enable and master select.
// - fault flag clears by status read while set, then control write.
// - while fault set, output enable and master select cannot be set, except by the control write that clears it.
// - a slave never sets the fault flag.
// - receive buffer keeps first byte after done flag clear; no overrun flag.
// - data reads return the buffered received byte.
// - request only when one of done/fault sets while the other is clear.
// - request drives an external interrupt line, chosen by source select.
// - two instances at indexes f0h-f3h and f8h-fbh.
// - polarity sets the idle level of the serial clock.
// - eight clock pulses per byte, msb first, full duplex.
// - data writes ignored while done flag set until status read.
// - master clock is core clock over prescale, rate and half divider.
module spims_port #(
   parameter int NUM_PORTS = 2,
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire spims_pkg::spims_pin_in_t [NUM_PORTS-1:0] pin_in,
   output spims_pkg::spims_pin_out_t [NUM_PORTS-1:0] pin_out,
   input wire logic [NUM_PORTS-1:0] ext_irq_in,
   output logic [NUM_PORTS-1:0] ext_irq_line
);
   import spims_pkg::*;

   // ==========================================================================
   // apb decode
   // ==========================================================================
   logic acc, setup, addr_ok;
   logic [7:0] idx, rd_mux, port_rdata [NUM_PORTS];
   logic [NUM_PORTS-1:0] port_hit;

   // upper address bits and byte offset must be zero for a hit
   assign idx = paddr[9:2];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
   assign acc = psel & penable;
   assign setup = psel & ~penable;
   // zero wait states: the answer comes in the first access cycle
   assign pready = acc;
   assign pslverr = acc & ~(|port_hit);

   // or together the per-port read values, only the hit port is non-zero
   always_comb
   begin
      rd_mux = 8'h00;
      for (int k = 0; k < NUM_PORTS; k++)
      begin
         rd_mux = rd_mux | port_rdata[k];
      end
   end

   // read data is captured in the setup cycle so it comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup)
         prdata <= {24'h00_0000, rd_mux};
   end

   // ==========================================================================
   // one serial port per instance
   // ==========================================================================
   for (genvar i = 0; i < NUM_PORTS; i++)
   begin : g_port
      logic [7:0] ctrl, divr, sreg, rx_buf, ctrl_wr_val, shifted;
      logic done_f, clash_f, fault_f, done_arm, clash_arm, fault_arm, done_clr, clash_clr;
      logic fault_clr, hit_data, hit_ctrl, hit_flags, hit_div, wr_data, rd_data, wr_ctrl;
      logic wr_div, rd_flags, master_select, oe, cpol, cpha, slv_en, m_run, sck_tog, s_byte, s_drv;
      logic sck_prev, tx_bit, irq_pulse, busy, wr_take, clash_evt, fault_evt, start;
      logic m_tick, s_edge, edge_any, lead, sample, drive, din, byte_done;
      logic [HALF_W-1:0] half_cnt, half_len;
      logic [3:0] m_edges;
      logic [2:0] bit_cnt;

      // --- register decode, sampled in the access phase ---
      assign hit_data = addr_ok && (idx == DATA_IDX[i]);
      assign hit_ctrl = addr_ok && (idx == CTRL_IDX[i]);
      assign hit_flags = addr_ok && (idx == FLAGS_IDX[i]);
      assign hit_div = addr_ok && (idx == DIV_IDX[i]);
      assign port_hit[i] = hit_data | hit_ctrl | hit_flags | hit_div;
      assign wr_data = acc & pwrite & hit_data;
      assign rd_data = acc & ~pwrite & hit_data;
      assign wr_ctrl = acc & pwrite & hit_ctrl;
      assign wr_div = acc & pwrite & hit_div;
      assign rd_flags = acc & ~pwrite & hit_flags;

      assign master_select = ctrl[CTL_MASTER];
      assign oe = ctrl[CTL_PIN_OE];
      assign cpol = ctrl[CTL_CPOL];
      assign cpha = ctrl[CTL_CPHA];
      assign slv_en = oe & ~master_select;

      // --- read values; flags register has unused bits at zero ---
      always_comb
      begin
         port_rdata[i] = 8'h00;
         if (hit_data)
            port_rdata[i] = rx_buf;
         else if (hit_ctrl)
            port_rdata[i] = ctrl;
         else if (hit_div)
            port_rdata[i] = divr;
         else if (hit_flags)
         begin
            port_rdata[i][ST_DONE] = done_f;
            port_rdata[i][ST_CLASH] = clash_f;
            port_rdata[i][ST_FAULT] = fault_f;
         end
      end

      // --- transfer busy: master shifting, or slave selected (phase zero) or inside a byte (phase one) ---
      assign busy = m_run
         | (slv_en & (cpha ? s_byte : ~pin_in[i].ss_n));
      assign clash_evt = wr_data & busy;
      assign wr_take = wr_data & ~busy & (~done_f | done_arm);
      assign fault_evt = master_select & ~pin_in[i].ss_n;
      assign start = wr_take & master_select & oe & ~fault_evt;

      // --- control write value: guard bits may only fall while a fault is set and no status read has armed its clear ---
      always_comb
      begin
         ctrl_wr_val = pwdata[7:0];
         if (fault_f & ~fault_arm)
            ctrl_wr_val = (pwdata[7:0] & ~CTL_GUARD_MASK)
               | (pwdata[7:0] & ctrl & CTL_GUARD_MASK);
      end

      // control register; a fault overrides a write in the same cycle
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            ctrl <= CTRL_RESET;
         else
         begin
            if (wr_ctrl)
               ctrl <= ctrl_wr_val;
            if (fault_evt)
            begin
               ctrl[CTL_PIN_OE] <= 1'b0;
               ctrl[CTL_MASTER] <= 1'b0;
            end
         end
      end

      // prescaler register, reserved bits forced to zero
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            divr <= DIV_RESET;
         else if (wr_div)
            divr <= pwdata[7:0] & DIV_WMASK;
      end

      // half period in core clocks: (prs+1) * rate/2 * (bypass ? 1 : 2)
      assign half_len = HALF_W'({5'h00, 1'b0, divr[DIV_PRS_HI:0]} + 9'h001)
         << (RATE_SHIFT[ctrl[CTL_RATE_HI:CTL_RATE_LO]]
            + {2'h0, ~divr[DIV_HALF_BYPASS]});

      // ========================================================================
      // master clock generator
      // ========================================================================
      assign m_tick = m_run & (half_cnt == half_len - 9'h001);

      // sixteen half periods per byte; the toggle ends at zero, so idle = polarity
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            m_run <= 1'b0;
            half_cnt <= '0;
            m_edges <= 4'h0;
            sck_tog <= 1'b0;
         end
         else if (fault_evt)
         begin
            m_run <= 1'b0;
            sck_tog <= 1'b0;
         end
         else if (start)
         begin
            m_run <= 1'b1;
            half_cnt <= '0;
            m_edges <= 4'h0;
            sck_tog <= 1'b0;
         end
         else if (m_tick)
         begin
            half_cnt <= '0;
            sck_tog <= ~sck_tog;
            m_edges <= m_edges + 4'h1;
            if (m_edges == LAST_EDGE)
               m_run <= 1'b0;
         end
         else if (m_run)
            half_cnt <= half_cnt + 9'h001;
      end

      // ========================================================================
      // edge classification shared by master and slave
      // ========================================================================
      // slave clock is a plain synchronous input; compare with last cycle
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            sck_prev <= 1'b0;
         else
            sck_prev <= pin_in[i].sck;
      end

      assign s_edge = slv_en & ~pin_in[i].ss_n & (pin_in[i].sck != sck_prev);
      assign edge_any = master_select ? m_tick : s_edge;
      // leading edge leaves the idle level
      assign lead = master_select ? ~m_edges[0] : (pin_in[i].sck != cpol);
      assign sample = edge_any & (lead ^ cpha);
      assign drive = edge_any & ~(lead ^ cpha);
      assign din = master_select ? pin_in[i].miso : pin_in[i].mosi;
      assign shifted = {sreg[BYTE_BITS-2:0], din};
      assign byte_done = sample & (bit_cnt == LAST_BIT);

      // shift register: loaded by an accepted write, shifted on sample edges
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            sreg <= DATA_RESET;
         else if (wr_take)
            sreg <= pwdata[7:0];
         else if (sample)
            sreg <= shifted;
      end

      // bit counter restarts per byte and whenever a slave is deselected
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            bit_cnt <= 3'h0;
         else if (start | (~master_select & pin_in[i].ss_n))
            bit_cnt <= 3'h0;
         else if (sample)
            bit_cnt <= bit_cnt + 3'h1;
      end

      // slave byte window and phase-one output permission
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            s_byte <= 1'b0;
            s_drv <= 1'b0;
         end
         else if (~slv_en | pin_in[i].ss_n)
         begin
            s_byte <= 1'b0;
            s_drv <= 1'b0;
         end
         else
         begin
            if (byte_done)
               s_byte <= 1'b0;
            else if (s_edge)
               s_byte <= 1'b1;
            if (s_edge & lead)
               s_drv <= 1'b1;
         end
      end

      // output bit: updated on drive edges; phase zero shows msb while idle
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            tx_bit <= 1'b0;
         else if (wr_take & ~cpha)
            tx_bit <= pwdata[7];
         else if (drive)
            tx_bit <= sreg[BYTE_BITS-1];
         else if (~cpha & ~m_run & ~s_byte)
            tx_bit <= sreg[BYTE_BITS-1];
      end

      // ========================================================================
      // status flags; a setting event wins over a clear in the same cycle
      // ========================================================================
      assign done_clr = done_arm & rd_data;
      assign clash_clr = clash_arm & (rd_data | wr_data);
      assign fault_clr = fault_arm & wr_ctrl;

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            done_f <= 1'b0;
            done_arm <= 1'b0;
         end
         else
         begin
            done_f <= byte_done | (done_f & ~done_clr);
            if (done_clr | byte_done)
               done_arm <= 1'b0;
            else if (rd_flags & done_f)
               done_arm <= 1'b1;
         end
      end

      // only the first byte after a clear reaches the buffer, later ones drop
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            rx_buf <= DATA_RESET;
         else if (byte_done & (~done_f | done_clr))
            rx_buf <= shifted;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            clash_f <= 1'b0;
            clash_arm <= 1'b0;
         end
         else
         begin
            clash_f <= clash_evt | (clash_f & ~clash_clr);
            if (clash_clr | clash_evt)
               clash_arm <= 1'b0;
            else if (rd_flags & clash_f)
               clash_arm <= 1'b1;
         end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            fault_f <= 1'b0;
            fault_arm <= 1'b0;
         end
         else
         begin
            fault_f <= fault_evt | (fault_f & ~fault_clr);
            if (fault_clr | fault_evt)
               fault_arm <= 1'b0;
            else if (rd_flags & fault_f)
               fault_arm <= 1'b1;
         end
      end

      // ========================================================================
      // interrupt request and pins
      // ========================================================================
      // one-cycle pulse gives the external channel its rising edge; clash excluded
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            irq_pulse <= 1'b0;
         else
            irq_pulse <= ctrl[CTL_IRQ_EN]
               & ((byte_done & ~done_f & ~fault_f)
                  | (fault_evt & ~fault_f & ~done_f));
      end

      assign ext_irq_line[i] = ctrl[CTL_IRQ_SRC] ? irq_pulse : ext_irq_in[i];

      // outputs released when the port is disabled; enables are active low
      assign pin_out[i].sck = cpol ^ sck_tog;
      assign pin_out[i].sck_oe_n = ~(oe & master_select);
      assign pin_out[i].mosi = tx_bit;
      assign pin_out[i].mosi_oe_n = ~(oe & master_select);
      assign pin_out[i].miso = tx_bit;
      assign pin_out[i].miso_oe_n = ~(slv_en & ~pin_in[i].ss_n
         & (~cpha | s_drv));
   end

endmodule : spims_port

/* test/spims_assertions.sv */
// concurrent checks on the register bus and pins of the dual serial port
`timescale 1ns/1ps
module spims_assertions #(
   parameter int NUM_PORTS = 2,
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire spims_pkg::spims_pin_in_t [NUM_PORTS-1:0] pin_in,
   input wire spims_pkg::spims_pin_out_t [NUM_PORTS-1:0] pin_out,
   input wire logic [NUM_PORTS-1:0] ext_irq_in,
   input wire logic [NUM_PORTS-1:0] ext_irq_line
);
   import spims_pkg::*;
   // ==========================================================================
   // checks
   // ==========================================================================
   logic mapped;
   // only the two blocks of four indexes answer; the page is not decoded
   assign mapped = (paddr[ADDR_W-1:10] == '0) && (paddr[9:2] inside {[8'hf0:8'hf3], [8'hf8:8'hfb]});
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("error response outside an access phase");
   map_decode_a: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
      else $error("error response does not match the register map");
   read_width_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data above the byte lane not zero");
   fault_release_a: assert property (!pin_out[0].sck_oe_n && !pin_out[0].mosi_oe_n && !pin_in[0].ss_n
      |-> ##[1:4] pin_out[0].sck_oe_n && pin_out[0].mosi_oe_n)
      else $error("master outputs not released after select went low");
   roles_apart_a: assert property (!pin_out[0].mosi_oe_n |-> pin_out[0].miso_oe_n)
      else $error("master and slave data outputs driven together");
   slave_release_a: assert property ($rose(pin_in[0].ss_n) |-> ##[1:3] pin_out[0].miso_oe_n)
      else $error("deselected slave still drives its data output");
   irq_pulse_a: assert property ($rose(ext_irq_line[0]) && !ext_irq_in[0]
      |=> !ext_irq_line[0] || ext_irq_in[0])
      else $error("interrupt request longer than one cycle");
   // main scenarios reached
   cover property (!pin_out[0].sck_oe_n && !pin_in[0].ss_n);
   cover property ($rose(ext_irq_line[0]));
   cover property (pslverr);
endmodule : spims_assertions
bind spims_port spims_assertions #(.NUM_PORTS(NUM_PORTS), .ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
   .pin_out(pin_out), .ext_irq_in(ext_irq_in), .ext_irq_line(ext_irq_line));

/* test/spims_partner.sv */
// behavioural slave device on the far side of port 0
`timescale 1ns/1ps
module spims_partner (
   input wire logic pclk,
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   logic prev_sck = 1'b0, wobble = 1'b0, started = 1'b0, bit_q = 1'b0, out_q = 1'b0;
   logic [7:0] shreg = 8'h00;
   // edges are seen at the core clock, far faster than the serial clock
   always @(posedge pclk)
   begin
      prev_sck <= sck;
      wobble <= ~wobble;
      if (sel_n)
      begin
         shreg <= tx_byte;
         started <= 1'b0;
      end
      else if (sck != prev_sck && sck != cpol)
      begin
         bit_q <= mosi;
         out_q <= shreg[7];
         started <= 1'b1;
      end
      else if (sck != prev_sck)
         shreg <= {shreg[6:0], cpha ? mosi : bit_q};
   end
   // released line wobbles so a stale bit never passes for data
   assign miso = (sel_n || (cpha && !started)) ? wobble : (cpha ? out_q : shreg[7]);
   assign rx_byte = shreg;
endmodule : spims_partner

/* test/spi_master_slave_port_bench.sv */
// self-checking bench for the dual serial port with a slave partner on port 0
`timescale 1ns/1ps
module spi_master_slave_port_bench;
   import spims_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, miso_far;
   spims_pin_in_t [1:0] pin_in;
   spims_pin_out_t [1:0] pin_out;
   logic [1:0] ext_irq_in = 2'h0, ext_irq_line;
   logic dut_ss_n = 1'b1;
   logic sel_n = 1'b1, cpol = 1'b0, cpha = 1'b0;
   logic [7:0] far_tx = 8'h00, far_rx, tx;
   logic [8:0] exp_q[$];
   logic [8:0] note;
   int miscompares = 0, check_count = 0, irq_cnt = 0, n;
   // ==========================================================================
   // clock, wires and instances
   // ==========================================================================
   initial
   begin
      forever #2 pclk = ~pclk;
   end
   // clock and mosi lines that nobody drives are pulled low
   assign pin_in[0] = '{sck: !pin_out[0].sck_oe_n && pin_out[0].sck,
      mosi: !pin_out[0].mosi_oe_n && pin_out[0].mosi,
      miso: pin_out[0].miso_oe_n ? miso_far : pin_out[0].miso, ss_n: dut_ss_n};
   assign pin_in[1] = '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
   spims_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .ext_irq_in(ext_irq_in),
      .ext_irq_line(ext_irq_line));
   spims_partner u_far (.pclk(pclk), .sck(pin_in[0].sck), .mosi(pin_in[0].mosi), .sel_n(sel_n),
      .cpol(cpol), .cpha(cpha), .tx_byte(far_tx), .miso(miso_far), .rx_byte(far_rx));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one bus cycle; request held until ready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] idx, input logic [8:0] exp);
      exp_q.push_back(exp);
      apb(1'b0, idx, 8'h00);
   endtask : rd
   task automatic wait_irq();
      int start = irq_cnt;
      for (int i = 0; i < 400 && irq_cnt == start; i++) @(posedge pclk);
      check("irq seen", 8'(irq_cnt != start), 8'h01);
   endtask : wait_irq
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // read results are matched against the oldest note
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         note = exp_q.pop_front();
         check("bus error", {7'h0, pslverr}, {7'h0, note[8]});
         if (!note[8])
            check("read data", prdata[7:0], note[7:0]);
      end
      if (ext_irq_line[0] === 1'b1)
         irq_cnt++;
   end
   // hang guard, far above the several hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      give_verdict();
   end
   // ==========================================================================
   // tests
   // ==========================================================================
   initial
   begin
      void'($urandom(56));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++)
         rd(8'hf0 + 8'(i) + (i > 3 ? 8'h04 : 8'h00), 9'h000);
      rd(8'hf4, 9'h100);
      apb(1'b1, DIV_IDX[0], 8'hff);
      rd(DIV_IDX[0], {1'b0, DIV_WMASK});
      apb(1'b1, DIV_IDX[0], 8'h11);
      $display("test registers done");
      // every polarity and phase, with a clash and a write while done is set
      for (int m = 0; m < 4; m++)
      begin
         cpol <= m[1];
         cpha <= m[0];
         tx = 8'($urandom);
         far_tx <= 8'($urandom);
         apb(1'b1, CTRL_IDX[0], {4'hf, m[1], m[0], 2'b01});
         sel_n <= 1'b0;
         @(posedge pclk);
         apb(1'b1, DATA_IDX[0], tx);
         apb(1'b1, DATA_IDX[0], ~tx);
         wait_irq();
         repeat (12) @(posedge pclk);
         apb(1'b1, DATA_IDX[0], 8'h5a);
         repeat (6) @(posedge pclk);
         check("idle clock", {7'h0, pin_out[0].sck}, {7'h0, cpol});
         check("far side byte", far_rx, tx);
         sel_n <= 1'b1;
         rd(FLAGS_IDX[0], 9'h0c0);
         rd(DATA_IDX[0], {1'b0, far_tx});
         rd(FLAGS_IDX[0], 9'h000);
      end
      $display("test master transfers done");
      dut_ss_n <= 1'b0;
      wait_irq();
      dut_ss_n <= 1'b1;
      apb(1'b1, CTRL_IDX[0], 8'hf1);
      rd(CTRL_IDX[0], 9'h0a1);
      rd(FLAGS_IDX[0], 9'h010);
      apb(1'b1, CTRL_IDX[0], 8'hf1);
      rd(CTRL_IDX[0], 9'h0f1);
      rd(FLAGS_IDX[0], 9'h000);
      $display("test mode fault done");
      n = irq_cnt;
      apb(1'b1, CTRL_IDX[0], 8'he4);
      dut_ss_n <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b1, DATA_IDX[0], 8'h3c);
      rd(FLAGS_IDX[0], 9'h000);
      apb(1'b1, CTRL_IDX[0], 8'he0);
      apb(1'b1, DATA_IDX[0], 8'hc3);
      rd(FLAGS_IDX[0], 9'h040);
      rd(DATA_IDX[0], {1'b0, far_tx});
      rd(FLAGS_IDX[0], 9'h000);
      dut_ss_n <= 1'b1;
      check("irq count", 8'(irq_cnt), 8'(n));
      ext_irq_in[1] <= 1'b1;
      repeat (3) @(posedge pclk);
      check("irq line", {7'h0, ext_irq_line[1]}, 8'h01);
      ext_irq_in[1] <= 1'b0;
      repeat (3) @(posedge pclk);
      check("irq line", {7'h0, ext_irq_line[1]}, 8'h00);
      $display("test slave and irq source done");
      give_verdict();
   end
endmodule : spi_master_slave_port_bench
